// ### src/iep_ctrl.v
`include "iep_defs.vh"

module iep_ctrl
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [11:0] src_req,
   input wire ext_pin_two,
   input wire [3:0] port1_pins,
   input wire irq_ack,
   input wire irq_ret,
   output wire irq_req,
   output wire [3:0] irq_vector,
   output wire [1:0] irq_level,
   output wire wake_idle,
   output wire wake_halt
);
   reg [7:0] en_grp1_r;
   reg [5:0] irq_enable_group2_r;
   reg [5:0] irq_level_low_group1_r;
   reg [5:0] irq_level_high_group1_r;
   reg [5:0] irq_level_low_group2_r;
   reg [5:0] irq_level_high_group2_r;
   reg [3:0] port1_sel_r;
   reg pin2_edge_flag_r;
   reg port1_change_flag_r;
   reg [3:0] active_r;
   reg irq_req_r;
   reg [3:0] irq_vec_r;
   reg [1:0] irq_lvl_r;
   reg wake_idle_r;
   reg wake_halt_r;
   reg [31:0] prdata_r;
   reg pready_r;
   reg pslverr_r;

   reg [31:0] rdata_nxt;
   reg mapped_nxt;
   reg [3:0] active_nxt;

   wire [7:0] reg_idx;
   wire setup_ph;
   wire wr_done;
   wire pin2_fall;
   wire port1_change;
   wire [11:0] req_all;
   wire [11:0] en_all;
   wire [11:0] pend;
   wire [11:0] lvl_hi_all;
   wire [11:0] lvl_lo_all;
   wire global_irq_en;
   wire found;
   wire [3:0] best_idx;
   wire [1:0] best_lvl;
   wire cur_valid;
   wire [1:0] cur_lvl;
   wire grant;
   wire ack_pin2;
   wire ack_port1;
   wire timer2_level_hi;
   wire timer2_level_lo;
   wire uart1_level_hi;
   wire uart1_level_lo;
   wire timer1_level_hi;
   wire timer1_level_lo;
   wire pin1_level_hi;
   wire pin1_level_lo;
   wire timer0_level_hi;
   wire timer0_level_lo;
   wire pin0_level_hi;
   wire pin0_level_lo;
   wire uart2_level_hi;
   wire uart2_level_lo;
   wire spi_level_hi;
   wire spi_level_lo;
   wire adc_touch_level_hi;
   wire adc_touch_level_lo;
   wire pin2_level_hi;
   wire pin2_level_lo;
   wire port1_change_level_hi;
   wire port1_change_level_lo;
   wire timer3_level_hi;
   wire timer3_level_lo;

   assign reg_idx = paddr[9:2];
   assign setup_ph = psel & ~penable;
   // An access outside the decoded window is refused, so it must not write either.
   assign wr_done = psel & penable & pready_r & pwrite & (paddr[11:10] == 2'h0);

   iep_pin u_pin
   (
      .pclk(pclk),
      .presetn(presetn),
      .ext_pin_two(ext_pin_two),
      .port1_pins(port1_pins),
      .port1_sel(port1_sel_r),
      .pin2_fall(pin2_fall),
      .port1_change(port1_change)
   );

   // Pin two and port-1 change requests come from the local flags, not from src_req.
   assign req_all = {src_req[11:9], pin2_edge_flag_r, port1_change_flag_r, src_req[6:0]};

   assign global_irq_en = en_grp1_r[`IEP_BIT_GLOBAL_EN];
   assign en_all = {irq_enable_group2_r, en_grp1_r[5:0]};
   assign pend = req_all & en_all & {`IEP_NUM_SRC{global_irq_en}};

   // Each source's level pair is named so the register bit behind it stays plain.
   assign timer2_level_hi = irq_level_high_group1_r[`IEP_BIT_TIMER2];
   assign timer2_level_lo = irq_level_low_group1_r[`IEP_BIT_TIMER2];
   assign uart1_level_hi = irq_level_high_group1_r[`IEP_BIT_UART1];
   assign uart1_level_lo = irq_level_low_group1_r[`IEP_BIT_UART1];
   assign timer1_level_hi = irq_level_high_group1_r[`IEP_BIT_TIMER1];
   assign timer1_level_lo = irq_level_low_group1_r[`IEP_BIT_TIMER1];
   assign pin1_level_hi = irq_level_high_group1_r[`IEP_BIT_PIN1];
   assign pin1_level_lo = irq_level_low_group1_r[`IEP_BIT_PIN1];
   assign timer0_level_hi = irq_level_high_group1_r[`IEP_BIT_TIMER0];
   assign timer0_level_lo = irq_level_low_group1_r[`IEP_BIT_TIMER0];
   assign pin0_level_hi = irq_level_high_group1_r[`IEP_BIT_PIN0];
   assign pin0_level_lo = irq_level_low_group1_r[`IEP_BIT_PIN0];
   assign uart2_level_hi = irq_level_high_group2_r[`IEP_BIT_UART2];
   assign uart2_level_lo = irq_level_low_group2_r[`IEP_BIT_UART2];
   assign spi_level_hi = irq_level_high_group2_r[`IEP_BIT_SPI];
   assign spi_level_lo = irq_level_low_group2_r[`IEP_BIT_SPI];
   assign adc_touch_level_hi = irq_level_high_group2_r[`IEP_BIT_ADC_TOUCH];
   assign adc_touch_level_lo = irq_level_low_group2_r[`IEP_BIT_ADC_TOUCH];
   assign pin2_level_hi = irq_level_high_group2_r[`IEP_BIT_PIN2];
   assign pin2_level_lo = irq_level_low_group2_r[`IEP_BIT_PIN2];
   assign port1_change_level_hi = irq_level_high_group2_r[`IEP_BIT_PORT1];
   assign port1_change_level_lo = irq_level_low_group2_r[`IEP_BIT_PORT1];
   assign timer3_level_hi = irq_level_high_group2_r[`IEP_BIT_TIMER3];
   assign timer3_level_lo = irq_level_low_group2_r[`IEP_BIT_TIMER3];

   // Source numbers run from pin zero at bit 0 up to uart2 at bit 11.
   assign lvl_hi_all = {uart2_level_hi, spi_level_hi, adc_touch_level_hi, pin2_level_hi,
      port1_change_level_hi, timer3_level_hi, timer2_level_hi, uart1_level_hi,
      timer1_level_hi, pin1_level_hi, timer0_level_hi, pin0_level_hi};
   assign lvl_lo_all = {uart2_level_lo, spi_level_lo, adc_touch_level_lo, pin2_level_lo,
      port1_change_level_lo, timer3_level_lo, timer2_level_lo, uart1_level_lo,
      timer1_level_lo, pin1_level_lo, timer0_level_lo, pin0_level_lo};

   iep_arb u_arb
   (
      .pend(pend),
      .lvl_hi(lvl_hi_all),
      .lvl_lo(lvl_lo_all),
      .found(found),
      .idx(best_idx),
      .lvl(best_lvl)
   );

   assign cur_valid = |active_r;
   assign cur_lvl = active_r[3] ? 2'h3 : active_r[2] ? 2'h2 : active_r[1] ? 2'h1 : 2'h0;
   assign grant = found & (~cur_valid | (best_lvl > cur_lvl));

   assign ack_pin2 = irq_ack & irq_req_r & (irq_vec_r == `IEP_SRC_PIN2);
   assign ack_port1 = irq_ack & irq_req_r & (irq_vec_r == `IEP_SRC_PORT1);

   // A return pops the highest level in service; an ack then pushes the granted level.
   always @*
   begin
      active_nxt = active_r;
      if (irq_ret)
      begin
         if (active_r[3])
            active_nxt[3] = 1'b0;
         else if (active_r[2])
            active_nxt[2] = 1'b0;
         else if (active_r[1])
            active_nxt[1] = 1'b0;
         else
            active_nxt[0] = 1'b0;
      end
      if (irq_ack & irq_req_r)
         active_nxt[irq_lvl_r] = 1'b1;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active_r <= `IEP_RST_ACTIVE;
         irq_req_r <= 1'b0;
         irq_vec_r <= `IEP_RST_VEC;
         irq_lvl_r <= `IEP_RST_LVL;
         wake_idle_r <= 1'b0;
         wake_halt_r <= 1'b0;
      end
      else
      begin
         active_r <= active_nxt;
         // The request drops for one cycle after an ack so the core never sees a stale vector.
         if (irq_ack & irq_req_r)
            irq_req_r <= 1'b0;
         else
            irq_req_r <= grant;
         if (~(irq_ack & irq_req_r))
         begin
            irq_vec_r <= best_idx;
            irq_lvl_r <= best_lvl;
         end
         wake_idle_r <= |pend;
         // Halt wake follows the pin enable alone; port-1 change wakes with no enable.
         wake_halt_r <= (pin2_edge_flag_r & irq_enable_group2_r[`IEP_BIT_PIN2])
            | port1_change_flag_r;
      end
   end

   // Flags: hardware set wins over both the service clear and a software write of zero.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin2_edge_flag_r <= 1'b0;
         port1_change_flag_r <= 1'b0;
      end
      else
      begin
         if (pin2_fall)
            pin2_edge_flag_r <= 1'b1;
         else if (ack_pin2)
            pin2_edge_flag_r <= 1'b0;
         else if (wr_done & (reg_idx == `IEP_IDX_FLAGS) & ~pwdata[`IEP_BIT_PIN2_FLAG])
            pin2_edge_flag_r <= 1'b0;
         if (port1_change)
            port1_change_flag_r <= 1'b1;
         else if (ack_port1)
            port1_change_flag_r <= 1'b0;
         else if (wr_done & (reg_idx == `IEP_IDX_FLAGS) & ~pwdata[`IEP_BIT_P1_FLAG])
            port1_change_flag_r <= 1'b0;
      end
   end

   // Register writes take effect at the completing access edge only.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_grp1_r <= `IEP_RST_EN1;
         irq_enable_group2_r <= `IEP_RST_GRP;
         irq_level_low_group1_r <= `IEP_RST_GRP;
         irq_level_high_group1_r <= `IEP_RST_GRP;
         irq_level_low_group2_r <= `IEP_RST_GRP;
         irq_level_high_group2_r <= `IEP_RST_GRP;
         port1_sel_r <= `IEP_RST_P1SEL;
      end
      else if (wr_done)
      begin
         if (reg_idx == `IEP_IDX_EN_GRP1)
            en_grp1_r <= {pwdata[7], 1'b0, pwdata[5:0]};
         else if (reg_idx == `IEP_IDX_EN_GRP2)
            irq_enable_group2_r <= pwdata[5:0];
         else if (reg_idx == `IEP_IDX_LVL_LO1)
            irq_level_low_group1_r <= pwdata[5:0];
         else if (reg_idx == `IEP_IDX_LVL_HI1)
            irq_level_high_group1_r <= pwdata[5:0];
         else if (reg_idx == `IEP_IDX_LVL_LO2)
            irq_level_low_group2_r <= pwdata[5:0];
         else if (reg_idx == `IEP_IDX_LVL_HI2)
            irq_level_high_group2_r <= pwdata[5:0];
         else if (reg_idx == `IEP_IDX_P1_SEL)
            port1_sel_r <= pwdata[3:0];
      end
   end

   // Read decode; reserved bits read as zero.
   always @*
   begin
      rdata_nxt = `IEP_RST_DATA;
      mapped_nxt = 1'b1;
      if (paddr[11:10] != 2'h0)
         mapped_nxt = 1'b0;
      else if (reg_idx == `IEP_IDX_EN_GRP1)
         rdata_nxt[7:0] = en_grp1_r;
      else if (reg_idx == `IEP_IDX_EN_GRP2)
         rdata_nxt[5:0] = irq_enable_group2_r;
      else if (reg_idx == `IEP_IDX_LVL_LO1)
         rdata_nxt[5:0] = irq_level_low_group1_r;
      else if (reg_idx == `IEP_IDX_LVL_HI1)
         rdata_nxt[5:0] = irq_level_high_group1_r;
      else if (reg_idx == `IEP_IDX_LVL_LO2)
         rdata_nxt[5:0] = irq_level_low_group2_r;
      else if (reg_idx == `IEP_IDX_LVL_HI2)
         rdata_nxt[5:0] = irq_level_high_group2_r;
      else if (reg_idx == `IEP_IDX_P1_SEL)
         rdata_nxt[3:0] = port1_sel_r;
      else if (reg_idx == `IEP_IDX_FLAGS)
      begin
         rdata_nxt[`IEP_BIT_PIN2_FLAG] = pin2_edge_flag_r;
         rdata_nxt[`IEP_BIT_P1_FLAG] = port1_change_flag_r;
      end
      else if (reg_idx == `IEP_IDX_STATUS)
         rdata_nxt[8:0] = {irq_req_r, irq_vec_r, active_r};
      else
         mapped_nxt = 1'b0;
   end

   // Zero-wait slave: ready rises for exactly the access cycle after each setup cycle.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= `IEP_RST_DATA;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= setup_ph;
         // The error is rebuilt every cycle so it can never outlive its own ready.
         pslverr_r <= setup_ph & ~mapped_nxt;
         if (setup_ph)
            prdata_r <= pwrite ? `IEP_RST_DATA : rdata_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq_req = irq_req_r;
   assign irq_vector = irq_vec_r;
   assign irq_level = irq_lvl_r;
   assign wake_idle = wake_idle_r;
   assign wake_halt = wake_halt_r;
endmodule // iep_ctrl

// ### src/iep_defs.vh
`ifndef IEP_DEFS_VH
`define IEP_DEFS_VH

// Register indices; the APB byte address is four times the index.
`define IEP_IDX_EN_GRP1 8'ha8
`define IEP_IDX_EN_GRP2 8'ha9
`define IEP_IDX_LVL_LO1 8'hb8
`define IEP_IDX_LVL_HI1 8'hb9
`define IEP_IDX_LVL_LO2 8'hba
`define IEP_IDX_LVL_HI2 8'hbb
`define IEP_IDX_FLAGS 8'h95
`define IEP_IDX_P1_SEL 8'h94
`define IEP_IDX_STATUS 8'hc0

// Field positions.
`define IEP_BIT_GLOBAL_EN 7
`define IEP_BIT_PIN2_FLAG 2
`define IEP_BIT_P1_FLAG 1
`define IEP_BIT_UART2 5
`define IEP_BIT_SPI 4
`define IEP_BIT_ADC_TOUCH 3
`define IEP_BIT_PIN2 2
`define IEP_BIT_PORT1 1
`define IEP_BIT_TIMER3 0
`define IEP_BIT_TIMER2 5
`define IEP_BIT_UART1 4
`define IEP_BIT_TIMER1 3
`define IEP_BIT_PIN1 2
`define IEP_BIT_TIMER0 1
`define IEP_BIT_PIN0 0

// Source numbers; group-one sources 0..5, group-two sources 6..11.
`define IEP_SRC_PORT1 4'h7
`define IEP_SRC_PIN2 4'h8
`define IEP_NUM_SRC 12
`define IEP_GRP_W 6

// Reset values.
`define IEP_RST_EN1 8'h00
`define IEP_RST_GRP 6'h00
`define IEP_RST_P1SEL 4'h0
`define IEP_RST_ACTIVE 4'h0
`define IEP_RST_VEC 4'h0
`define IEP_RST_LVL 2'h0
`define IEP_RST_DATA 32'h0000_0000

`endif

// ### src/iep_arb.v
// Picks the highest-level pending source; on equal levels the lower source number wins.
module iep_arb
(
   input wire [11:0] pend,
   input wire [11:0] lvl_hi,
   input wire [11:0] lvl_lo,
   output wire found,
   output wire [3:0] idx,
   output wire [1:0] lvl
);
   wire [12:0] c_found;
   wire [51:0] c_idx;
   wire [25:0] c_lvl;

   assign c_found[12] = 1'b0;
   assign c_idx[51:48] = 4'h0;
   assign c_lvl[25:24] = 2'h0;

   genvar i;
   generate
      for (i = 0; i < 12; i = i + 1)
      begin : g_chain
         wire [1:0] my_lvl;
         wire take;
         localparam [3:0] SRC_NUM = i;
         assign my_lvl = {lvl_hi[i], lvl_lo[i]};
         assign take = pend[i] & (~c_found[i+1] | (my_lvl >= c_lvl[2*i+3:2*i+2]));
         assign c_found[i] = take | c_found[i+1];
         assign c_idx[4*i+3:4*i] = take ? SRC_NUM : c_idx[4*i+7:4*i+4];
         assign c_lvl[2*i+1:2*i] = take ? my_lvl : c_lvl[2*i+3:2*i+2];
      end
   endgenerate

   assign found = c_found[0];
   assign idx = c_idx[3:0];
   assign lvl = c_lvl[1:0];
endmodule // iep_arb

// ### src/iep_pin.v
// Detects a falling edge on the second external pin and a change on selected port-1 pins.
`include "iep_defs.vh"

module iep_pin
(
   input wire pclk,
   input wire presetn,
   input wire ext_pin_two,
   input wire [3:0] port1_pins,
   input wire [3:0] port1_sel,
   output wire pin2_fall,
   output wire port1_change
);
   reg pin2_prev_r;
   reg [3:0] p1_prev_r;
   reg primed_r;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin2_prev_r <= 1'b1;
         p1_prev_r <= `IEP_RST_P1SEL;
         primed_r <= 1'b0;
      end
      else
      begin
         pin2_prev_r <= ext_pin_two;
         p1_prev_r <= port1_pins;
         primed_r <= 1'b1;
      end
   end

   // The first cycle after reset has no valid history, so no change is reported then.
   assign pin2_fall = primed_r & pin2_prev_r & ~ext_pin_two;
   assign port1_change = primed_r & |((p1_prev_r ^ port1_pins) & port1_sel);
endmodule // iep_pin

// ### dv/iep_core_model.sv
module iep_core_model
(
   input wire pclk,
   input wire presetn,
   input wire irq_req,
   input wire take,
   input wire ret_go,
   output logic irq_ack,
   output logic irq_ret
);
   timeunit 1ns;
   timeprecision 1ps;
   // The ack is one pulse, since the request drops after it and a held ack would be stale.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_ack <= 1'b0;
         irq_ret <= 1'b0;
      end
      else
      begin
         irq_ack <= irq_req && take && !irq_ack;
         irq_ret <= ret_go && !irq_ret;
      end
   end
endmodule // iep_core_model

// ### dv/iep_ctrl_sva.sv
module iep_ctrl_sva
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire irq_ack,
   input wire irq_req,
   input wire [3:0] irq_vector,
   input wire wake_idle,
   input wire wake_halt
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_unmapped_err: assert property (psel && !penable && paddr == 12'h000 |=> pslverr)
      else $error("unmapped access not refused");
   chk_mapped_ok: assert property (psel && !penable && paddr == 12'h2a4 |=> !pslverr)
      else $error("mapped access refused");
   chk_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
      else $error("read data on write");
   chk_ack_drops: assert property (irq_req && irq_ack |=> !irq_req)
      else $error("request held after ack");
   chk_vector_range: assert property (irq_req |-> irq_vector < 4'hc)
      else $error("vector out of range");
   chk_reset_quiet: assert property ($rose(presetn) |-> !irq_req && !wake_idle && !wake_halt)
      else $error("outputs active after reset");
endmodule // iep_ctrl_sva
bind iep_ctrl iep_ctrl_sva u_sva
(
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .irq_ack(irq_ack),
   .irq_req(irq_req),
   .irq_vector(irq_vector),
   .wake_idle(wake_idle),
   .wake_halt(wake_halt)
);

// ### dv/iep_ctrl_tb.sv
module iep_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [11:0] src_req = 12'h000;
   logic ext_pin_two = 1'b1;
   logic [3:0] port1_pins = 4'h0;
   logic take = 1'b0;
   logic ret_go = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, irq_ack, irq_ret, irq_req, wake_idle, wake_halt;
   wire [3:0] irq_vector;
   wire [1:0] irq_level;
   logic [31:0] rd, wd;
   logic err;
   logic [11:0] hi, lo, rq;
   logic [6:0] p;
   logic [7:0] regs [6] = '{8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hba, 8'hbb};
   int gs [4] = '{6, 9, 10, 11};
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   int k;
   always #2.5 pclk = ~pclk;
   iep_ctrl dut
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .src_req(src_req),
      .ext_pin_two(ext_pin_two),
      .port1_pins(port1_pins),
      .irq_ack(irq_ack),
      .irq_ret(irq_ret),
      .irq_req(irq_req),
      .irq_vector(irq_vector),
      .irq_level(irq_level),
      .wake_idle(wake_idle),
      .wake_halt(wake_halt)
   );
   iep_core_model core
   (
      .pclk(pclk),
      .presetn(presetn),
      .irq_req(irq_req),
      .take(take),
      .ret_go(ret_go),
      .irq_ack(irq_ack),
      .irq_ret(irq_ret)
   );
   task automatic final_report;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 20)
      begin
         t++;
         @(posedge pclk);
      end
      if (t == 20)
      begin
         n_fail++;
         $display("CHECK FAILED %0t bus answer timeout", $time);
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Walking down with >= lets the lower source number win a tie.
   function automatic logic [6:0] pick(input logic [11:0] q, h, l);
      logic [6:0] b = 7'h00;
      for (int s = 11; s >= 0; s--)
         if (q[s] && (!b[6] || {h[s], l[s]} >= b[1:0]))
            b = {1'b1, 4'(s), h[s], l[s]};
      return b;
   endfunction
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         $display("CHECK FAILED %0t run timeout", $time);
         final_report();
      end
   end
   initial
   begin
      k = $urandom(49);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[i])
      begin
         apb(1'b0, regs[i], 32'h0000_0000);
         chk(rd, 32'h0000_0000, "reset value");
      end
      foreach (regs[i])
      begin
         wd = $urandom;
         apb(1'b1, regs[i], wd);
         apb(1'b0, regs[i], 32'h0000_0000);
         chk(rd, wd & (i ? 32'h0000_003f : 32'h0000_00bf), "read back");
      end
      apb(1'b1, 8'h00, 32'hffff_ffff);
      chk(err, 1'b1, "unmapped error");
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped data");
      apb(1'b1, 8'ha8, 8'hbf);
      apb(1'b1, 8'ha9, 8'h3f);
      for (int it = 0; it < 24; it++)
      begin
         hi = $urandom;
         lo = $urandom;
         apb(1'b1, 8'hb8, lo[5:0]);
         apb(1'b1, 8'hb9, hi[5:0]);
         apb(1'b1, 8'hba, lo[11:6]);
         apb(1'b1, 8'hbb, hi[11:6]);
         rq = (it == 1) ? 12'he7f : (it == 0) ? 12'h000 : $urandom & 12'he7f;
         src_req <= rq;
         repeat (3) @(posedge pclk);
         p = pick(rq, hi, lo);
         chk({irq_req, irq_vector, irq_level}, p, "grant");
         chk(wake_idle, |rq, "idle wake");
         if (p[6])
         begin
            take <= 1'b1;
            repeat (3) @(posedge pclk);
            take <= 1'b0;
            k = $urandom % 10;
            k = (k > 6) ? k + 2 : k;
            src_req <= 12'h001 << k;
            chk(irq_req, 1'b0, "drop after ack");
            repeat (3) @(posedge pclk);
            chk(irq_req, {hi[k], lo[k]} > p[1:0], "preempt");
            src_req <= 12'h000;
            ret_go <= 1'b1;
            @(posedge pclk);
            ret_go <= 1'b0;
            repeat (2) @(posedge pclk);
         end
      end
      apb(1'b1, 8'ha8, 8'h80);
      src_req <= 12'he40;
      foreach (gs[i])
      begin
         apb(1'b1, 8'ha9, 8'h01 << (gs[i] - 6));
         repeat (3) @(posedge pclk);
         chk({irq_req, irq_vector}, {1'b1, 4'(gs[i])}, "enable gate");
      end
      apb(1'b1, 8'ha8, 8'h3f);
      apb(1'b1, 8'ha9, 8'h00);
      apb(1'b1, 8'h94, 8'h01);
      ext_pin_two <= 1'b0;
      port1_pins <= 4'h1;
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'h95, 32'h0000_0000);
      chk(rd, 32'h0000_0006, "flags set");
      chk(wake_halt, 1'b1, "change wake");
      apb(1'b1, 8'ha9, 8'h04);
      repeat (3) @(posedge pclk);
      chk({irq_req, wake_idle}, 2'b00, "global off");
      apb(1'b1, 8'ha8, 8'h80);
      repeat (3) @(posedge pclk);
      chk({irq_req, irq_vector}, 5'h18, "pin two request");
      take <= 1'b1;
      repeat (4) @(posedge pclk);
      take <= 1'b0;
      apb(1'b0, 8'h95, 32'h0000_0000);
      chk(rd, 32'h0000_0002, "service clear");
      apb(1'b1, 8'h95, 8'hfd);
      apb(1'b0, 8'h95, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "write zero clear");
      final_report();
   end
endmodule // iep_ctrl_tb
